//--- bct_consts.vh
// constants for the configuration decode and type 1 to type 0 translation block
// assumes pci command encodings on the c/be lines during the address phase
`ifndef BCT_CONSTS_VH
`define BCT_CONSTS_VH

// bus commands
`define BCT_CMD_CFG_RD   4'ha
`define BCT_CMD_CFG_WR   4'hb
`define BCT_CMD_SPECIAL  4'h1

// address type codes in ad[1:0]
`define BCT_TYPE0        2'h0
`define BCT_TYPE1        2'h1

// address field positions
`define BCT_BUS_HI       23
`define BCT_BUS_LO       16
`define BCT_DEV_HI       15
`define BCT_DEV_LO       11
`define BCT_REG_HI       7
`define BCT_REG_LO       2

// special cycle selectors
`define BCT_DEV_SPECIAL  5'h1f
`define BCT_REG_SPECIAL  6'h00

// clocks from frame to master abort
`define BCT_MABORT_CLKS  3'h5

// values
`define BCT_ONES         32'hffff_ffff
`define BCT_ZERO32       32'h0000_0000
`define BCT_BE_ALL_N     4'h0

`endif

//--- bct_cfg_xlate.v
// configuration claim for own space and type 1 to type 0 downstream translation
// assumes bridge already owns the secondary bus; pin inputs synchronous to ref_clk
// Contract
// - claim type 0: cfg command, 00b, idsel
// - ignore type 0 seen on secondary side
// - function number ignored for own space
// - one dword, disconnect with first transfer
// - reads return all four bytes always
// - own space bypasses buffers, completes immediately
// - claim type 1 when bus matches secondary
// - type 0 generated only on secondary bus
// - force 00b, clear 15:11, keep fields
// - devices 0..15 drive one idsel bit
// - devices 10h..1eh no idsel, still forwarded
// - device 1fh register 0 write makes special cycle
// - unselected secondary transaction ends master abort
// - translated accesses delayed, single dword each
// - master abort after five clocks, set status
// - master abort: all ones or target abort
`timescale 1ns/100ps
`default_nettype none
`include "bct_consts.vh"

module bct_cfg_xlate (
	input  wire        ref_clk,
	input  wire        rst,
	input  wire        p_frame_n,
	input  wire        p_irdy_n,
	input  wire        p_idsel,
	input  wire [31:0] p_ad_in,
	input  wire [3:0]  p_cbe_n_in,
	output wire [31:0] p_ad_out,
	output wire        p_ad_oe_n,
	output wire        p_devsel_n,
	output wire        p_trdy_n,
	output wire        p_stop_n,
	output wire        s_frame_n,
	output wire        s_irdy_n,
	output wire [31:0] s_ad_out,
	output wire        s_ad_oe_n,
	output wire [3:0]  s_cbe_n_out,
	output wire        s_cbe_oe_n,
	input  wire [31:0] s_ad_in,
	input  wire        s_devsel_n,
	input  wire        s_trdy_n,
	input  wire        s_stop_n,
	input  wire [7:0]  sec_bus_num,
	input  wire        mabort_mode,
	input  wire        rcv_mabort_clr,
	output wire        rcv_mabort,
	output wire [5:0]  cfg_reg,
	input  wire [31:0] cfg_rd_data,
	output wire        cfg_wr,
	output wire [31:0] cfg_wr_data,
	output wire [3:0]  cfg_be_n
);

	localparam P_IDLE = 4'h1;
	localparam P_CFG  = 4'h2;
	localparam P_DLY  = 4'h4;
	localparam P_END  = 4'h8;

	localparam S_IDLE = 4'h1;
	localparam S_ADDR = 4'h2;
	localparam S_DATA = 4'h4;
	localparam S_TURN = 4'h8;

	reg  [3:0]  p_state_r;
	reg         frm_q_r;
	reg  [31:0] p_ad_out_r;
	reg         p_ad_oe_n_r;
	reg         p_devsel_n_r;
	reg         p_trdy_n_r;
	reg         p_stop_n_r;
	reg  [5:0]  cfg_reg_r;
	reg         cfg_is_wr_r;
	reg         cfg_wr_r;
	reg  [31:0] cfg_wr_data_r;
	reg  [3:0]  cfg_be_n_r;
	reg  [31:0] cur_addr_r;
	reg  [3:0]  cur_cmd_r;
	reg         pend_r;
	reg  [31:0] req_addr_r;
	reg  [3:0]  req_cmd_r;
	reg  [3:0]  req_be_n_r;
	reg  [31:0] req_wdata_r;

	reg  [3:0]  s_state_r;
	reg         s_frame_n_r;
	reg         s_irdy_n_r;
	reg  [31:0] s_ad_out_r;
	reg         s_ad_oe_n_r;
	reg  [3:0]  s_cbe_n_r;
	reg         s_cbe_oe_n_r;
	reg  [2:0]  clk_cnt_r;
	reg         done_r;
	reg         mab_r;
	reg         tab_r;
	reg  [31:0] rdata_r;
	reg         rcv_mabort_r;

	// address phase decode watches primary pins only, so secondary type 0 never claims
	wire        addr_start = frm_q_r & ~p_frame_n;
	wire        is_cfg     = (p_cbe_n_in == `BCT_CMD_CFG_RD) | (p_cbe_n_in == `BCT_CMD_CFG_WR);
	wire        claim0     = is_cfg & (p_ad_in[1:0] == `BCT_TYPE0) & p_idsel;
	wire        claim1     = is_cfg & (p_ad_in[1:0] == `BCT_TYPE1) &
		(p_ad_in[`BCT_BUS_HI:`BCT_BUS_LO] == sec_bus_num);
	wire        match      = (cur_addr_r == req_addr_r) & (cur_cmd_r == req_cmd_r);
	wire        cur_rd     = (cur_cmd_r == `BCT_CMD_CFG_RD);

	wire [4:0]  req_dev  = req_addr_r[`BCT_DEV_HI:`BCT_DEV_LO];
	wire [5:0]  req_reg  = req_addr_r[`BCT_REG_HI:`BCT_REG_LO];
	wire        req_wr   = (req_cmd_r == `BCT_CMD_CFG_WR);
	wire        req_spec = req_wr & (req_dev == `BCT_DEV_SPECIAL) &
		(req_reg == `BCT_REG_SPECIAL);
	// one-hot idsel for devices 0..15, none above
	wire [15:0] idsel    = req_dev[4] ? 16'h0000 : (16'h0001 << req_dev[3:0]);
	wire [31:0] xlat_adr = {idsel, 5'h00, req_addr_r[10:2], `BCT_TYPE0};

	assign p_ad_out    = p_ad_out_r;
	assign p_ad_oe_n   = p_ad_oe_n_r;
	assign p_devsel_n  = p_devsel_n_r;
	assign p_trdy_n    = p_trdy_n_r;
	assign p_stop_n    = p_stop_n_r;
	assign s_frame_n   = s_frame_n_r;
	assign s_irdy_n    = s_irdy_n_r;
	assign s_ad_out    = s_ad_out_r;
	assign s_ad_oe_n   = s_ad_oe_n_r;
	assign s_cbe_n_out = s_cbe_n_r;
	assign s_cbe_oe_n  = s_cbe_oe_n_r;
	assign rcv_mabort  = rcv_mabort_r;
	assign cfg_reg     = cfg_reg_r;
	assign cfg_wr      = cfg_wr_r;
	assign cfg_wr_data = cfg_wr_data_r;
	assign cfg_be_n    = cfg_be_n_r;

	// primary side: target only, never drives an address phase
	always @(posedge ref_clk) begin
		if (rst) begin
			p_state_r     <= P_IDLE;
			frm_q_r       <= 1'b1;
			p_ad_out_r    <= `BCT_ZERO32;
			p_ad_oe_n_r   <= 1'b1;
			p_devsel_n_r  <= 1'b1;
			p_trdy_n_r    <= 1'b1;
			p_stop_n_r    <= 1'b1;
			cfg_reg_r     <= 6'h00;
			cfg_is_wr_r   <= 1'b0;
			cfg_wr_r      <= 1'b0;
			cfg_wr_data_r <= `BCT_ZERO32;
			cfg_be_n_r    <= 4'hf;
			cur_addr_r    <= `BCT_ZERO32;
			cur_cmd_r     <= 4'h0;
			pend_r        <= 1'b0;
			req_addr_r    <= `BCT_ZERO32;
			req_cmd_r     <= 4'h0;
			req_be_n_r    <= 4'hf;
			req_wdata_r   <= `BCT_ZERO32;
		end else begin
			frm_q_r  <= p_frame_n;
			cfg_wr_r <= 1'b0;
			case (p_state_r)
				P_IDLE: begin
					if (addr_start && claim0) begin
						// function bits 10:8 are not looked at
						cfg_reg_r    <= p_ad_in[`BCT_REG_HI:`BCT_REG_LO];
						cfg_is_wr_r  <= (p_cbe_n_in == `BCT_CMD_CFG_WR);
						p_devsel_n_r <= 1'b0;
						p_state_r    <= P_CFG;
					end else if (addr_start && claim1) begin
						cur_addr_r   <= p_ad_in;
						cur_cmd_r    <= p_cbe_n_in;
						p_devsel_n_r <= 1'b0;
						p_state_r    <= P_DLY;
					end
				end
				P_CFG: begin
					// no buffer or pending check: answer at once
					if (!p_irdy_n && p_trdy_n_r) begin
						p_trdy_n_r <= 1'b0;
						p_stop_n_r <= p_frame_n;
						if (!cfg_is_wr_r) begin
							p_ad_out_r  <= cfg_rd_data;
							p_ad_oe_n_r <= 1'b0;
						end
					end else if (!p_irdy_n && !p_trdy_n_r) begin
						cfg_wr_r      <= cfg_is_wr_r;
						cfg_wr_data_r <= p_ad_in;
						cfg_be_n_r    <= p_cbe_n_in;
						p_trdy_n_r    <= 1'b1;
						p_ad_oe_n_r   <= 1'b1;
						p_state_r     <= P_END;
					end
				end
				P_DLY: begin
					if (!p_irdy_n && !pend_r) begin
						// latch new delayed request and retry
						req_addr_r  <= cur_addr_r;
						req_cmd_r   <= cur_cmd_r;
						req_be_n_r  <= p_cbe_n_in;
						req_wdata_r <= p_ad_in;
						pend_r      <= 1'b1;
						p_stop_n_r  <= 1'b0;
						p_state_r   <= P_END;
					end else if (!p_irdy_n && match && done_r) begin
						pend_r    <= 1'b0;
						p_state_r <= P_END;
						if (tab_r || (mab_r && mabort_mode && !req_spec)) begin
							p_devsel_n_r <= 1'b1;
							p_stop_n_r   <= 1'b0;
						end else begin
							p_trdy_n_r <= 1'b0;
							p_stop_n_r <= p_frame_n;
							if (cur_rd) begin
								p_ad_out_r  <= rdata_r;
								p_ad_oe_n_r <= 1'b0;
							end
						end
					end else if (!p_irdy_n) begin
						p_stop_n_r <= 1'b0;
						p_state_r  <= P_END;
					end
				end
				P_END: begin
					p_trdy_n_r  <= 1'b1;
					p_ad_oe_n_r <= 1'b1;
					if (p_frame_n) begin
						p_devsel_n_r <= 1'b1;
						p_stop_n_r   <= 1'b1;
						p_state_r    <= P_IDLE;
					end
				end
				default: begin
					p_state_r <= P_IDLE;
				end
			endcase
		end
	end

	// secondary side: issue translated type 0 or special cycle, one data phase
	always @(posedge ref_clk) begin
		if (rst) begin
			s_state_r    <= S_IDLE;
			s_frame_n_r  <= 1'b1;
			s_irdy_n_r   <= 1'b1;
			s_ad_out_r   <= `BCT_ZERO32;
			s_ad_oe_n_r  <= 1'b1;
			s_cbe_n_r    <= 4'h0;
			s_cbe_oe_n_r <= 1'b1;
			clk_cnt_r    <= 3'h0;
			done_r       <= 1'b0;
			mab_r        <= 1'b0;
			tab_r        <= 1'b0;
			rdata_r      <= `BCT_ZERO32;
			rcv_mabort_r <= 1'b0;
		end else begin
			if (!pend_r) begin
				done_r <= 1'b0;
			end
			if (rcv_mabort_clr) begin
				rcv_mabort_r <= 1'b0;
			end
			case (s_state_r)
				S_IDLE: begin
					if (pend_r && !done_r) begin
						s_frame_n_r  <= 1'b0;
						s_ad_out_r   <= req_spec ? req_addr_r : xlat_adr;
						s_ad_oe_n_r  <= 1'b0;
						s_cbe_n_r    <= req_spec ? `BCT_CMD_SPECIAL : req_cmd_r;
						s_cbe_oe_n_r <= 1'b0;
						clk_cnt_r    <= 3'h0;
						s_state_r    <= S_ADDR;
					end
				end
				S_ADDR: begin
					// single data phase: frame ends with the address
					s_frame_n_r <= 1'b1;
					s_irdy_n_r  <= 1'b0;
					s_cbe_n_r   <= req_spec ? `BCT_BE_ALL_N : req_be_n_r;
					s_ad_out_r  <= req_wdata_r;
					s_ad_oe_n_r <= ~req_wr;
					clk_cnt_r   <= 3'h1;
					s_state_r   <= S_DATA;
				end
				S_DATA: begin
					if (clk_cnt_r != `BCT_MABORT_CLKS) begin
						clk_cnt_r <= clk_cnt_r + 3'h1;
					end
					if (!s_devsel_n && !s_trdy_n) begin
						rdata_r   <= s_ad_in;
						mab_r     <= 1'b0;
						tab_r     <= 1'b0;
						done_r    <= 1'b1;
						s_state_r <= S_TURN;
					end else if (!s_devsel_n && !s_stop_n) begin
						s_state_r <= S_TURN;
					end else if (s_devsel_n && !s_stop_n) begin
						rdata_r   <= `BCT_ONES;
						mab_r     <= 1'b0;
						tab_r     <= 1'b1;
						done_r    <= 1'b1;
						s_state_r <= S_TURN;
					end else if (s_devsel_n && (clk_cnt_r == `BCT_MABORT_CLKS)) begin
						// no idsel hit or special cycle: nobody claims
						rdata_r      <= `BCT_ONES;
						mab_r        <= 1'b1;
						tab_r        <= 1'b0;
						rcv_mabort_r <= 1'b1;
						done_r       <= 1'b1;
						s_state_r    <= S_TURN;
					end
					if ((!s_trdy_n || !s_stop_n) || (s_devsel_n &&
						(clk_cnt_r == `BCT_MABORT_CLKS))) begin
						s_irdy_n_r   <= 1'b1;
						s_ad_oe_n_r  <= 1'b1;
						s_cbe_oe_n_r <= 1'b1;
					end
				end
				S_TURN: begin
					s_state_r <= S_IDLE;
				end
				default: begin
					s_state_r <= S_IDLE;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

//--- bct_cfg_xlate_sva.sv
// checker for the configuration claim and type 1 to type 0 translation
// assumes one clock and the top module ports only
`timescale 1ns/100ps
`default_nettype none
module bct_cfg_xlate_chk (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        p_frame_n,
	input wire logic        p_devsel_n,
	input wire logic        p_trdy_n,
	input wire logic        p_stop_n,
	input wire logic        p_ad_oe_n,
	input wire logic        s_frame_n,
	input wire logic        s_irdy_n,
	input wire logic [31:0] s_ad_out,
	input wire logic [3:0]  s_cbe_n_out,
	input wire logic        s_ad_oe_n,
	input wire logic        s_cbe_oe_n,
	input wire logic        s_devsel_n,
	input wire logic        rcv_mabort
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence sec_start;
		$fell(s_frame_n) && s_cbe_n_out != 4'h1;
	endsequence
	sequence no_devsel;
		sec_start ##1 s_devsel_n[*5];
	endsequence
	a_trdy_one_pulse: assert property (!p_trdy_n |=> p_trdy_n)
		else $error("trdy held too long");
	a_trdy_has_devsel: assert property (!p_trdy_n |-> !p_devsel_n)
		else $error("trdy without devsel");
	a_ad_oe_trdy: assert property (!p_ad_oe_n |-> !p_trdy_n)
		else $error("primary ad driven without trdy");
	a_stop_holds: assert property (!p_stop_n && !p_frame_n |=> !p_stop_n)
		else $error("stop dropped while frame low");
	a_release_end: assert property (p_frame_n && p_trdy_n && (!p_stop_n || $rose(p_trdy_n))
		|=> p_devsel_n && p_stop_n)
		else $error("devsel or stop not released");
	a_sec_drive_en: assert property (!s_frame_n |-> !s_ad_oe_n && !s_cbe_oe_n)
		else $error("secondary address phase not driven");
	a_sec_single: assert property (!s_frame_n |=> s_frame_n && !s_irdy_n)
		else $error("secondary frame longer than one cycle");
	a_sec_addr_form: assert property (sec_start |-> s_ad_out[1:0] == 2'h0 &&
		s_ad_out[15:11] == 5'h00 && $onehot0(s_ad_out[31:16]))
		else $error("bad translated address");
	a_mabort_flag: assert property (no_devsel |-> ##[1:2] rcv_mabort)
		else $error("master abort not flagged");
endmodule
bind bct_cfg_xlate bct_cfg_xlate_chk bct_cfg_xlate_chk_i (.ref_clk, .rst, .p_frame_n,
	.p_devsel_n, .p_trdy_n, .p_stop_n, .p_ad_oe_n, .s_frame_n, .s_irdy_n, .s_ad_out,
	.s_cbe_n_out, .s_ad_oe_n, .s_cbe_oe_n, .s_devsel_n, .rcv_mabort);
`default_nettype wire

//--- bct_tgt_model.sv
// secondary bus configuration target with selectable response delay
// assumes type 0 cycles with one data phase from the bridge
`timescale 1ns/100ps
`default_nettype none
module bct_tgt_model #(
	parameter DEV  = 3,
	parameter DATA = 32'h1234_5678
) (
	input wire logic        ref_clk,
	input wire logic [1:0]  lat,
	input wire logic [1:0]  term,
	input wire logic        s_frame_n,
	input wire logic [31:0] s_ad_out,
	output logic            s_devsel_n,
	output logic            s_trdy_n,
	output logic            s_stop_n,
	output logic [31:0]     s_ad_in
);
	logic [1:0]  cnt;
	logic        hit;
	logic [31:0] got;
	logic        tried;
	logic        abrt;
	initial begin
		s_devsel_n = 1'b1;
		s_trdy_n = 1'b1;
		s_stop_n = 1'b1;
		s_ad_in = 32'h0000_0000;
		hit = 1'b0;
		tried = 1'b0;
		abrt = 1'b0;
	end
	always @(posedge ref_clk) begin
		s_devsel_n <= 1'b1;
		s_trdy_n <= 1'b1;
		s_stop_n <= 1'b1;
		s_ad_in <= ~s_ad_in;
		abrt <= 1'b0;
		// second cycle of a target abort: stop without devsel
		if (abrt) begin
			s_stop_n <= 1'b0;
		end
		// only type 0 with own idsel line is claimed
		if (!s_frame_n && s_ad_out[1:0] == 2'h0 && s_ad_out[16 + DEV]) begin
			hit <= 1'b1;
			cnt <= lat;
		end else if (hit && cnt != 2'd0) begin
			cnt <= cnt - 2'd1;
		end else if (hit && term == 2'd1 && !tried) begin
			// first attempt retried, bridge must reissue it
			hit <= 1'b0;
			tried <= 1'b1;
			s_devsel_n <= 1'b0;
			s_stop_n <= 1'b0;
		end else if (hit && term == 2'd2) begin
			hit <= 1'b0;
			abrt <= 1'b1;
			s_devsel_n <= 1'b0;
		end else if (hit) begin
			hit <= 1'b0;
			tried <= 1'b0;
			s_devsel_n <= 1'b0;
			s_trdy_n <= 1'b0;
			s_ad_in <= DATA;
			got <= s_ad_out;
		end
	end
endmodule
`default_nettype wire

//--- bct_cfg_xlate_bench.sv
// bench for own space claims and downstream type 0 translation
// assumes the design, its checker and the secondary target model
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
	$display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module bct_cfg_xlate_bench;
	logic        ref_clk, rst, p_frame_n, p_irdy_n, p_idsel, mabort_mode, rcv_mabort_clr;
	logic [31:0] p_ad_in, p_ad_out, s_ad_out, s_ad_in, cfg_rd_data, cfg_wr_data, s_addr, w_data;
	logic [3:0]  p_cbe_n_in, s_cbe_n_out, cfg_be_n, s_cmd, w_be;
	logic        p_ad_oe_n, p_devsel_n, p_trdy_n, p_stop_n, s_frame_n, s_irdy_n, s_ad_oe_n;
	logic        s_cbe_oe_n, s_devsel_n, s_trdy_n, s_stop_n, rcv_mabort, cfg_wr;
	logic [5:0]  cfg_reg;
	logic [1:0]  lat, term;
	wire  [7:0]  sec_bus_num = 8'h05;
	int          n_errors, n_compared;
	assign cfg_rd_data = {16'ha5a5, 10'h000, cfg_reg};
	bct_cfg_xlate bct_cfg_xlate_i (.ref_clk, .rst, .p_frame_n, .p_irdy_n, .p_idsel, .p_ad_in,
		.p_cbe_n_in, .p_ad_out, .p_ad_oe_n, .p_devsel_n, .p_trdy_n, .p_stop_n, .s_frame_n,
		.s_irdy_n, .s_ad_out, .s_ad_oe_n, .s_cbe_n_out, .s_cbe_oe_n, .s_ad_in, .s_devsel_n,
		.s_trdy_n, .s_stop_n, .sec_bus_num, .mabort_mode, .rcv_mabort_clr, .rcv_mabort,
		.cfg_reg, .cfg_rd_data, .cfg_wr, .cfg_wr_data, .cfg_be_n);
	bct_tgt_model bct_tgt_model_i (.ref_clk, .lat, .term, .s_frame_n, .s_ad_out, .s_devsel_n,
		.s_trdy_n, .s_stop_n, .s_ad_in);
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (!s_frame_n) begin
			s_addr <= s_ad_out;
			s_cmd <= s_cbe_n_out;
		end
		if (cfg_wr) begin
			w_data <= cfg_wr_data;
			w_be <= cfg_be_n;
		end
	end
	task automatic xfer(input logic [31:0] a, input logic [3:0] cmd, input logic sel, brst,
		input logic [31:0] wd, output logic [2:0] r, output logic [31:0] rd);
		@(posedge ref_clk);
		p_frame_n <= 1'b0;
		p_ad_in <= a;
		p_cbe_n_in <= cmd;
		p_idsel <= sel;
		@(posedge ref_clk);
		p_frame_n <= !brst;
		p_irdy_n <= 1'b0;
		p_cbe_n_in <= 4'h6;
		p_ad_in <= wd;
		r = 3'b111;
		for (int i = 0; i < 10 && r[1:0] == 2'b11; i++) begin
			@(posedge ref_clk);
			r = {p_devsel_n, p_trdy_n, p_stop_n};
		end
		rd = p_ad_out;
		p_frame_n <= 1'b1;
		p_irdy_n <= !brst;
		p_ad_in <= ~wd;
		@(posedge ref_clk);
		p_irdy_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
	endtask
	task automatic dly(input logic [31:0] a, input logic [3:0] cmd, input logic [31:0] wd,
		output logic [2:0] r, output logic [31:0] rd);
		int n = 0;
		do begin
			xfer(a, cmd, 1'b0, 1'b0, wd, r, rd);
			n++;
		end while (r == 3'b010 && n < 20);
	endtask
	task automatic t_own;
		logic [2:0]  r;
		logic [31:0] d;
		xfer(32'h0000_07a8, 4'ha, 1'b1, 1'b1, 32'h0, r, d);
		`CHK(r, 3'b000)
		`CHK(d, 32'ha5a5_002a)
		xfer(32'h0000_0714, 4'hb, 1'b1, 1'b0, 32'hcafe_f00d, r, d);
		`CHK(r, 3'b001)
		`CHK({w_be, w_data}, 36'h6_cafe_f00d)
		`CHK(cfg_reg, 6'h05)
		xfer(32'h0000_0004, 4'ha, 1'b0, 1'b0, 32'h0, r, d);
		`CHK(r, 3'b111)
		xfer(32'h0000_0004, 4'h6, 1'b1, 1'b0, 32'h0, r, d);
		`CHK(r, 3'b111)
	endtask
	task automatic t_xlate;
		logic [2:0]  r;
		logic [31:0] d;
		int          devs[6] = '{0, 3, 15, 16, 30, 31};
		foreach (devs[k]) begin
			dly({16'h0005, devs[k][4:0], 3'h5, 6'h09, 2'h1}, 4'ha, 32'h0, r, d);
			`CHK(s_addr, ((devs[k] < 16) ? 32'h1 << (16 + devs[k]) : 32'h0) | 32'h524)
			`CHK(d, (devs[k] == 3) ? 32'h1234_5678 : 32'hffff_ffff)
			`CHK(rcv_mabort, devs[k] != 3)
			rcv_mabort_clr <= 1'b1;
			@(posedge ref_clk);
			rcv_mabort_clr <= 1'b0;
		end
		mabort_mode <= 1'b1;
		dly(32'h0005_2801, 4'hb, 32'h1, r, d);
		`CHK(r, 3'b110)
		dly(32'h0005_ff01, 4'hb, 32'h0000_beef, r, d);
		`CHK({s_cmd, s_addr, r}, 39'h0_8002_ff80_9)
		mabort_mode <= 1'b0;
		lat <= 2'd3;
		dly(32'h0005_1805, 4'hb, 32'h5a5a_0ff0, r, d);
		`CHK(bct_tgt_model_i.got, 32'h5a5a_0ff0)
		dly(32'h0006_1805, 4'hb, 32'h0, r, d);
		`CHK(r, 3'b111)
	endtask
	task automatic t_sec_term;
		logic [2:0]  r;
		logic [31:0] d;
		lat <= 2'd0;
		term <= 2'd1;
		dly(32'h0005_1809, 4'ha, 32'h0, r, d);
		`CHK({r, d}, 35'h1_1234_5678)
		term <= 2'd2;
		dly(32'h0005_180d, 4'ha, 32'h0, r, d);
		`CHK(r, 3'b110)
		term <= 2'd0;
	endtask
	task automatic results;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		{rst, p_frame_n, p_irdy_n} = 3'b111;
		{p_idsel, mabort_mode, rcv_mabort_clr, lat, term} = 7'h00;
		p_ad_in = 32'h0;
		p_cbe_n_in = 4'hf;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		t_own;
		t_xlate;
		t_sec_term;
		results;
	end
	initial begin
		#40000;
		n_errors++;
		results;
	end
endmodule
`default_nettype wire
